// [rtl/ctfc_pkg.sv]
// Purpose: Constants and carrier types for the current/temperature fault configuration bank
// Assumes: 50 MHz core clock, command codes fixed at build
// Notes:   Timing counts come from window times and the clock period
package ctfc_pkg;

  // Clock
  localparam int unsigned CLK_NS = 20;

  // Command codes
  localparam logic [7:0] CMD_OC_RESP   = 8'h47;
  localparam logic [7:0] CMD_OC_WARN   = 8'h4a;
  localparam logic [7:0] CMD_UC_FAULT  = 8'h4b;
  localparam logic [7:0] CMD_OT_FAULT  = 8'h4f;
  localparam logic [7:0] CMD_OT_WARN   = 8'h51;

  // Reset values
  localparam logic [7:0]  RST_OC_RESP  = 8'h80;
  localparam logic [15:0] RST_OC_WARN  = 16'he0d0;
  localparam logic [15:0] RST_UC_FAULT = 16'h0008;
  localparam logic [15:0] RST_OT_FAULT = 16'h008c;
  localparam logic [15:0] RST_OT_WARN  = 16'h0073;

  // Response byte fields
  localparam int unsigned ACT_MSB   = 7;
  localparam int unsigned ACT_LSB   = 6;
  localparam int unsigned RETRY_MSB = 5;
  localparam int unsigned RETRY_LSB = 3;
  localparam int unsigned DLY_MSB   = 2;
  localparam int unsigned DLY_LSB   = 0;
  localparam logic [1:0] ACT_HOLD    = 2'h0;
  localparam logic [1:0] ACT_UV_END  = 2'h1;
  localparam logic [1:0] ACT_DELAYED = 2'h2;
  localparam logic [1:0] ACT_SHUT    = 2'h3;
  localparam logic [2:0] RETRY_NONE  = 3'h0;
  localparam logic [2:0] RETRY_ALWAYS = 3'h7;

  // LINEAR11 layout and limits
  localparam int unsigned EXP_MSB  = 15;
  localparam int unsigned EXP_LSB  = 11;
  localparam logic [4:0]  EXP_WARN = 5'h1c;
  localparam logic [4:0]  EXP_ZERO = 5'h00;
  localparam logic [15:0] UC_MIN   = 16'h0005;
  localparam logic [15:0] UC_MAX   = 16'h000c;
  localparam logic [10:0] OTF_MIN  = 11'h050;
  localparam logic [10:0] OTF_MAX  = 11'h0a0;
  localparam logic [10:0] OTW_MIN  = 11'h046;
  localparam logic [10:0] OTW_MAX  = 11'h096;

  // Delay window lower bounds (least time), and retry wait
  localparam int unsigned DLY_MIN_NS [8] =
    '{160000, 320000, 640000, 1280000, 2560000, 5120000, 9600000, 10080000};
  localparam int unsigned HICCUP_NS = 1000000000;

  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c == 0) ? 1 : c;
  endfunction

  localparam int unsigned DLY_CYC_DEF [8] = '{
    ns_to_cyc(DLY_MIN_NS[0]), ns_to_cyc(DLY_MIN_NS[1]), ns_to_cyc(DLY_MIN_NS[2]),
    ns_to_cyc(DLY_MIN_NS[3]), ns_to_cyc(DLY_MIN_NS[4]), ns_to_cyc(DLY_MIN_NS[5]),
    ns_to_cyc(DLY_MIN_NS[6]), ns_to_cyc(DLY_MIN_NS[7])};
  localparam int unsigned HICCUP_CYC_DEF = ns_to_cyc(HICCUP_NS);

  // Host command carrier
  typedef struct packed {
    logic        write;
    logic [7:0]  cmd;
    logic [15:0] data;
  } ctfc_req_s;

  // Sticky status bits
  typedef struct packed {
    logic word_iout;
    logic byte_iout;
    logic byte_nota;
    logic iout_peak;
    logic iout_uc;
    logic cml_data;
  } ctfc_status_s;

  // Image handed to the nonvolatile store
  typedef struct packed {
    logic [7:0]  oc_resp;
    logic [15:0] oc_warn;
    logic [15:0] ot_fault;
  } ctfc_nv_s;

  typedef enum logic [2:0] {st_run, st_limit, st_hiccup, st_latched} ctfc_state_e;

endpackage

// [rtl/ctfc_sync3.sv]
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk
// Notes:   A rise is passed on once stages two and three agree high; the output clears while they differ and holds while both are low
`timescale 1ns/1ns
module ctfc_sync3 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Per-bit agreement filter
  always_ff @(posedge clk)
  begin
    if (rst)
      dout <= '0;
    else
      dout <= (s2 & s3) | (dout & ~(s2 ^ s3));
  end

endmodule

// [rtl/ctfc_bank.sv]
// Purpose: Current and temperature fault configuration bank with response sequencing
// Assumes: Host commands arrive on the link clock; analog flags are asynchronous
// Notes:   Commands cross to the core by a toggle handshake
// Contract
// - Peak fault sets status word, byte, current bit 7 and asserts alert
// - Fault bits stay set until clear-faults, not when condition goes
// - Over-current response byte resets to 80 hex, latch-off
// - Action 00 keeps running, current held at peak limit
// - Action 01 keeps running unless output under-voltage is seen
// - Action 10 limits for the delay, then applies retry if still limiting
// - Action 11 shuts output at once, then follows retry setting
// - Retry 000 never restarts; output stays off until cleared
// - Retry 111 restarts forever every 1 s until off or other fault
// - Writing unsupported encodings such as retry 001-110 raises invalid data
// - Delay field selects window from 160 us up to 10.08 ms
// - Warning limit exponent fixed at -4, resets 13 A, else invalid
// - Warning limit mantissa is not range checked
// - Negative limit accepts only 5-12 A exponent zero, resets 8 A
// - Negative fault sets none-of-above, word iout, under-current bit, alert
// - Temperature fault limit 80-160, exponent zero, resets 140
// - Temperature fault limit at or below warning limit is invalid
// - Response, warning and temperature limit saved on store-all command
// - Temperature warning limit at or above fault limit is invalid
`timescale 1ns/1ns
module ctfc_bank
  import ctfc_pkg::*;
#(
  parameter int unsigned DLY_CYC [8] = DLY_CYC_DEF,
  parameter int unsigned HICCUP_CYC  = HICCUP_CYC_DEF
) (
  // Core clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Link clock domain, host side
  input  wire logic         link_clk,
  input  wire logic         link_rst,
  input  wire logic         req_valid,
  output logic              req_ready,
  input  wire ctfc_req_s    req,
  output logic              rsp_valid,
  output logic [15:0]       rsp_data,
  // Analog flags and pins
  input  wire logic         peak_current_trip_flag,
  input  wire logic         negative_current_trip_flag,
  input  wire logic         vout_uv_flag,
  input  wire logic         enable_pin,
  input  wire logic         other_fault_flag,
  // Core-side controls
  input  wire logic         clear_faults,
  input  wire logic         store_user_all,
  // Results
  output ctfc_status_s      status,
  output logic              host_alert_n,
  output logic              output_on,
  output logic              current_limit,
  output logic              nv_store_valid,
  output ctfc_nv_s          nv_image
);

  // Link domain
  ctfc_req_s   req_hold;
  logic        req_tgl, busy, ack_seen, ack_sync;
  // Core domain
  logic        req_sync, req_seen, ack_tgl;
  logic        peak_s, neg_s, uv_s, en_s, other_s, peak_d, neg_d;
  logic        req_go, wr_go, bad_wr;
  logic [15:0] rsp_core, rd_word, uc_fault;
  logic [4:0]  pins_s, wexp;
  logic [7:0]  oc_resp;
  logic [10:0] oc_warn_m, ot_fault_m, ot_warn_m, wman;
  logic [25:0] cnt;
  ctfc_state_e state, retry_state;
  logic [1:0]  act;
  logic [2:0]  retry, dly_sel;

  // Host handshake is only refused while a command is in flight
  assign req_ready = ~busy;

  // Link side: hold request, flip toggle, wait for acknowledge
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      req_hold  <= '0;
      req_tgl   <= 1'b0;
      busy      <= 1'b0;
      ack_seen  <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (req_valid && !busy)
      begin
        req_hold <= req;
        req_tgl  <= ~req_tgl;
        busy     <= 1'b1;
      end
      else if (busy && (ack_sync != ack_seen))
      begin
        ack_seen  <= ack_sync;
        busy      <= 1'b0;
        rsp_valid <= 1'b1;
        rsp_data  <= rsp_core; // Stable since the acknowledge toggle flipped
      end
    end
  end

  ctfc_sync3 #(.W(1)) u_ack_sync (
    .clk  (link_clk),
    .rst  (link_rst),
    .din  (ack_tgl),
    .dout (ack_sync)
  );

  ctfc_sync3 #(.W(1)) u_req_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (req_tgl),
    .dout (req_sync)
  );

  ctfc_sync3 #(.W(5)) u_pin_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({peak_current_trip_flag, negative_current_trip_flag, vout_uv_flag,
            enable_pin, other_fault_flag}),
    .dout (pins_s)
  );

  assign {peak_s, neg_s, uv_s, en_s, other_s} = pins_s;

  // Request decode; held request words are stable while the toggle differs
  assign req_go  = req_sync != req_seen;
  assign wr_go   = req_go && req_hold.write;
  assign wexp    = req_hold.data[EXP_MSB:EXP_LSB];
  assign wman    = req_hold.data[EXP_LSB-1:0];
  assign act     = oc_resp[ACT_MSB:ACT_LSB];
  assign retry   = oc_resp[RETRY_MSB:RETRY_LSB];
  assign dly_sel = oc_resp[DLY_MSB:DLY_LSB];

  // Write legality per command
  always_comb
  begin
    bad_wr = 1'b0;
    if (req_hold.cmd == CMD_OC_RESP)
      bad_wr = (req_hold.data[RETRY_MSB:RETRY_LSB] != RETRY_NONE) &&
               (req_hold.data[RETRY_MSB:RETRY_LSB] != RETRY_ALWAYS);
    else if (req_hold.cmd == CMD_OC_WARN)
      bad_wr = wexp != EXP_WARN;
    else if (req_hold.cmd == CMD_UC_FAULT)
      bad_wr = (req_hold.data < UC_MIN) || (req_hold.data > UC_MAX);
    else if (req_hold.cmd == CMD_OT_FAULT)
      bad_wr = (wexp != EXP_ZERO) || (wman < OTF_MIN) || (wman > OTF_MAX)
               || (wman <= ot_warn_m);
    else if (req_hold.cmd == CMD_OT_WARN)
      bad_wr = (wexp != EXP_ZERO) || (wman < OTW_MIN) || (wman > OTW_MAX)
               || (wman >= ot_fault_m);
  end

  // Register writes; a rejected word leaves the target untouched
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      oc_resp    <= RST_OC_RESP;
      oc_warn_m  <= RST_OC_WARN[EXP_LSB-1:0];
      uc_fault   <= RST_UC_FAULT;
      ot_fault_m <= RST_OT_FAULT[EXP_LSB-1:0];
      ot_warn_m  <= RST_OT_WARN[EXP_LSB-1:0];
    end
    else if (wr_go && !bad_wr)
    begin
      if (req_hold.cmd == CMD_OC_RESP)
        oc_resp <= req_hold.data[7:0];
      else if (req_hold.cmd == CMD_OC_WARN)
        oc_warn_m <= wman;
      else if (req_hold.cmd == CMD_UC_FAULT)
        uc_fault <= req_hold.data;
      else if (req_hold.cmd == CMD_OT_FAULT)
        ot_fault_m <= wman;
      else if (req_hold.cmd == CMD_OT_WARN)
        ot_warn_m <= wman;
    end
  end

  // Read mux; fixed exponents are supplied from constants, warning and temperature limits store only mantissas
  always_comb
  begin
    rd_word = 16'h0000;
    if (req_hold.cmd == CMD_OC_RESP)
      rd_word = {8'h00, oc_resp};
    else if (req_hold.cmd == CMD_OC_WARN)
      rd_word = {EXP_WARN, oc_warn_m};
    else if (req_hold.cmd == CMD_UC_FAULT)
      rd_word = uc_fault;
    else if (req_hold.cmd == CMD_OT_FAULT)
      rd_word = {EXP_ZERO, ot_fault_m};
    else if (req_hold.cmd == CMD_OT_WARN)
      rd_word = {EXP_ZERO, ot_warn_m};
  end

  // Answer register and acknowledge toggle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      req_seen <= 1'b0;
      ack_tgl  <= 1'b0;
      rsp_core <= 16'h0000;
    end
    else if (req_go)
    begin
      req_seen <= req_sync;
      ack_tgl  <= ~ack_tgl;
      rsp_core <= req_hold.write ? 16'h0000 : rd_word;
    end
  end

  // Edge memory for fault events; idle-low after reset so no false edge
  always_ff @(posedge clk)
  begin
    {peak_d, neg_d} <= rst ? 2'b00 : {peak_s, neg_s};
  end

  // Sticky status; a set in the clearing cycle wins
  always_ff @(posedge clk)
  begin
    if (rst)
      status <= '0;
    else
    begin
      status.word_iout <= (status.word_iout & ~clear_faults) | (peak_s & ~peak_d)
                          | (neg_s & ~neg_d);
      status.byte_iout <= (status.byte_iout & ~clear_faults) | (peak_s & ~peak_d);
      status.iout_peak <= (status.iout_peak & ~clear_faults) | (peak_s & ~peak_d);
      status.byte_nota <= (status.byte_nota & ~clear_faults) | (neg_s & ~neg_d);
      status.iout_uc   <= (status.iout_uc & ~clear_faults) | (neg_s & ~neg_d);
      status.cml_data  <= (status.cml_data & ~clear_faults) | (wr_go & bad_wr);
    end
  end

  // Alert follows any sticky bit, one cycle behind; released during reset
  always_ff @(posedge clk)
  begin
    host_alert_n <= rst | ~(|status);
  end

  // Where the retry setting leads
  assign retry_state = (retry == RETRY_ALWAYS) ? st_hiccup : st_latched;

  // Fault response sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= st_run;
      cnt   <= '0;
    end
    else
    begin
      case (state)
        st_run:
        begin
          cnt <= '0;
          if (peak_s && (act == ACT_UV_END) && uv_s)
            state <= retry_state;
          else if (peak_s && (act == ACT_DELAYED))
            state <= st_limit;
          else if (peak_s && (act == ACT_SHUT))
            state <= retry_state;
        end
        st_limit:
        begin
          if (!peak_s)
            state <= st_run;
          else if (cnt == 26'(DLY_CYC[dly_sel] - 1))
          begin
            state <= retry_state;
            cnt   <= '0;
          end
          else
            cnt <= cnt + 26'h1;
        end
        st_hiccup:
        begin
          if (!en_s || other_s)
            state <= st_latched;
          else if (cnt == 26'(HICCUP_CYC - 1))
            state <= st_run;
          else
            cnt <= cnt + 26'h1;
        end
        default:
        begin
          cnt <= '0;
          if (clear_faults)
            state <= st_run;
        end
      endcase
    end
  end

  // Power stage controls, registered; reset holds the stage off
  always_ff @(posedge clk)
  begin
    output_on     <= !rst && en_s && (state inside {st_run, st_limit});
    current_limit <= !rst && peak_s && (state inside {st_run, st_limit});
  end

  // Snapshot for the nonvolatile store
  always_ff @(posedge clk)
  begin
    nv_store_valid <= store_user_all && !rst;
    if (rst)
      nv_image <= '0;
    else if (store_user_all)
      nv_image <= '{oc_resp, {EXP_WARN, oc_warn_m}, {EXP_ZERO, ot_fault_m}};
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_peak_event;
    peak_s && !peak_d;
  endsequence

  sequence s_peak_flags;
    status.word_iout && status.byte_iout && status.iout_peak ##1 !host_alert_n;
  endsequence

  a_peak_flags_alert: assert property (s_peak_event |=> s_peak_flags)
    else $error("peak fault flags or alert missing");
  a_flags_stay_set: assert property (status.iout_uc && !clear_faults |=> status.iout_uc)
    else $error("sticky flag dropped without clear");
  a_resp_reset_val: assert property ($fell(rst) |-> oc_resp == RST_OC_RESP)
    else $error("response byte reset value wrong");
  a_hold_keeps_on: assert property (state == st_run && act == ACT_HOLD && en_s |=> output_on)
    else $error("hold action lost output");
  a_uv_ends_run: assert property (state == st_run && peak_s && act == ACT_UV_END && uv_s
                                  |=> state != st_run)
    else $error("under-voltage did not end run");
  a_shut_now: assert property (state == st_run && peak_s && act == ACT_SHUT
                               |=> ##1 !output_on)
    else $error("shut action left output on");
  a_latch_holds: assert property (state == st_latched && !clear_faults |=> state == st_latched)
    else $error("latched state left without clear");
  a_bad_write_kept: assert property (wr_go && bad_wr && req_hold.cmd == CMD_OC_RESP
                                     |=> status.cml_data && $stable(oc_resp))
    else $error("bad response write not rejected");
  a_warn_exp_check: assert property (wr_go && req_hold.cmd == CMD_OC_WARN && wexp != EXP_WARN
                                     |=> $stable(oc_warn_m) && status.cml_data)
    else $error("warning exponent not checked");
  a_uc_in_range: assert property (uc_fault >= UC_MIN && uc_fault <= UC_MAX)
    else $error("negative limit out of range");
  a_ot_order: assert property (ot_fault_m > ot_warn_m)
    else $error("temperature limits out of order");

endmodule

// [tb/ctfc_host.sv]
// Purpose: Host model on the request link of the fault configuration bank
// Assumes: One request outstanding, lines driven on the falling link edge
// Notes:   Released request lines show the inverse of the last word
`timescale 1ns/1ns
module ctfc_host
  import ctfc_pkg::*;
(
  // Link clock
  input  wire logic        link_clk,
  // Request side
  output logic             req_valid,
  input  wire logic        req_ready,
  output ctfc_req_s        req,
  // Answer side
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data
);
  // Idle at time zero
  initial
  begin
    req_valid = 1'b0;
    req       = '0;
  end

  // Request held until a rising edge sees ready high, then the answer is awaited
  task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] data,
                      output logic [15:0] rdata);
    int n;
    n = 0;
    @(negedge link_clk);
    req_valid = 1'b1;
    req       = {wr, cmd, data};
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(negedge link_clk);
      n++;
    end
    @(posedge link_clk);
    @(negedge link_clk);
    req_valid = 1'b0;
    req       = ~req; // Stale word would hide a late sample
    while (rsp_valid !== 1'b1 && n < 200)
    begin
      @(negedge link_clk);
      n++;
    end
    rdata = (rsp_valid === 1'b1) ? rsp_data : 16'hxxxx; // A lost answer never matches
  endtask
endmodule

// [tb/ctfc_bank_bench.sv]
// Purpose: Self-checking bench for the fault configuration bank
// Assumes: Short delay and retry counts given through parameters
// Notes:   Flags change on the falling core edge, well clear of sampling
`timescale 1ns/1ns
module ctfc_bank_bench
  import ctfc_pkg::*;
;
  // Core side and link side signals
  logic         clk, rst, link_clk, link_rst;
  logic         pk, ng, uv, en, of, clr, sto;
  logic         req_valid, req_ready, rsp_valid, host_alert_n;
  logic         output_on, current_limit, nv_store_valid;
  ctfc_req_s    req;
  logic [15:0]  rsp_data, rd_w;
  ctfc_status_s status;
  ctfc_nv_s     nv_image;
  int           n_mismatch, tests_run, cyc;

  // Short counts keep delay and hiccup waits quick
  ctfc_bank #(.DLY_CYC('{4, 5, 6, 7, 8, 9, 10, 11}), .HICCUP_CYC(20)) dut (
    .clk, .rst, .link_clk, .link_rst, .req_valid, .req_ready, .req, .rsp_valid, .rsp_data,
    .peak_current_trip_flag(pk), .negative_current_trip_flag(ng), .vout_uv_flag(uv),
    .enable_pin(en), .other_fault_flag(of), .clear_faults(clr), .store_user_all(sto),
    .status, .host_alert_n, .output_on, .current_limit, .nv_store_valid, .nv_image);
  ctfc_host host (.link_clk, .req_valid, .req_ready, .req, .rsp_valid, .rsp_data);

  // Core clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Link clock, offset so the phases never line up
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  task automatic wrap_up();
    $display("mismatches %0d of %0d comparisons", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host.xfer(1'b1, c, d, rd_w);
    wc(2);
  endtask

  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    host.xfer(1'b0, c, 16'h0000, rd_w);
    chk(rd_w, e);
  endtask

  // Sticky bits only go on an explicit clear
  task automatic clear();
    @(negedge clk) clr = 1'b1;
    @(negedge clk) clr = 1'b0;
    wc(2);
  endtask

  // Write, then judge the invalid-data flag and what the register kept
  task automatic wtry(input logic [7:0] c, input logic [15:0] d, input logic bad,
                      input logic [15:0] keep);
    clear();
    wr(c, d);
    chk(16'(status.cml_data), 16'(bad));
    rdc(c, bad ? keep : d);
  endtask

  task automatic t_reset();
    rdc(CMD_OC_RESP, 16'h0080);
    rdc(CMD_OC_WARN, 16'he0d0);
    rdc(CMD_UC_FAULT, 16'h0008);
    rdc(CMD_OT_FAULT, 16'h008c);
    chk(16'(status), 16'h0000);
    chk(16'(host_alert_n), 16'h0001);
  endtask

  // Every action and retry code, delay field walked alongside
  task automatic t_resp();
    logic [7:0] d, keep;
    logic       bad;
    keep = 8'h80;
    for (int i = 0; i < 32; i++)
    begin
      d   = 8'({i[4:0], i[2:0]});
      bad = i[2:0] != 3'h0 && i[2:0] != 3'h7;
      wtry(CMD_OC_RESP, {8'h00, d}, bad, {8'h00, keep});
      if (!bad)
        keep = d;
    end
  endtask

  task automatic t_limits();
    logic [15:0] keep;
    logic        bad;
    wtry(CMD_OC_WARN, 16'he7ff, 1'b0, 16'h0000);
    wtry(CMD_OC_WARN, 16'h07ff, 1'b1, 16'he7ff);
    wtry(CMD_OC_WARN, 16'he890, 1'b1, 16'he7ff);
    wtry(CMD_OC_WARN, 16'he001, 1'b0, 16'h0000);
    keep = 16'h0008;
    for (int v = 4; v <= 13; v++)
    begin
      bad = v < 5 || v > 12;
      wtry(CMD_UC_FAULT, 16'(v), bad, keep);
      if (!bad)
        keep = 16'(v);
    end
    wtry(CMD_UC_FAULT, 16'h0806, 1'b1, keep);
    wtry(CMD_OT_FAULT, 16'h0073, 1'b1, 16'h008c);
    wtry(CMD_OT_FAULT, 16'h0074, 1'b0, 16'h0000);
    wtry(CMD_OT_FAULT, 16'h00a1, 1'b1, 16'h0074);
    wtry(CMD_OT_FAULT, 16'h0874, 1'b1, 16'h0074);
    wtry(CMD_OT_FAULT, 16'h00a0, 1'b0, 16'h0000);
    wtry(CMD_OT_FAULT, 16'h0078, 1'b0, 16'h0000);
    wtry(CMD_OT_WARN, 16'h0078, 1'b1, 16'h0073);
    wtry(CMD_OT_WARN, 16'h0077, 1'b0, 16'h0000);
  endtask

  // Latch-off default: bits stay after the trip goes away
  task automatic t_peak();
    wr(CMD_OC_RESP, 16'h0080);
    clear();
    pk = 1'b1;
    wc(20);
    chk(16'(status), 16'h0034);
    chk(16'(host_alert_n), 16'h0000);
    chk(16'(output_on), 16'h0000);
    pk = 1'b0;
    wc(30);
    chk(16'(status), 16'h0034);
    chk(16'(output_on), 16'h0000);
    clear();
    wc(8);
    chk(16'(host_alert_n), 16'h0001);
    chk(16'(output_on), 16'h0001);
  endtask

  task automatic t_neg();
    ng = 1'b1;
    wc(4);
    ng = 1'b0;
    wc(30);
    chk(16'(status), 16'h002a);
    chk(16'(host_alert_n), 16'h0000);
    clear();
  endtask

  // Peak fault held under one response setting, power stage watched
  task automatic act_run(input logic [7:0] r, input logic u, input logic e9,
                         input logic e29);
    wr(CMD_OC_RESP, {8'h00, r});
    clear();
    pk = 1'b1;
    wc(9);
    chk(16'(output_on), 16'(e9));
    chk(16'(current_limit), 16'(r[7:6] != 2'h3));
    uv = u;
    wc(20);
    chk(16'(output_on), 16'(e29));
    pk = 1'b0;
    uv = 1'b0;
    clear();
    wc(8);
  endtask

  // Restart after the wait, then a second fault during the wait latches
  task automatic t_hiccup();
    wr(CMD_OC_RESP, 16'h00f8);
    clear();
    pk = 1'b1;
    wc(9);
    chk(16'(output_on), 16'h0000);
    pk = 1'b0;
    wc(40);
    chk(16'(output_on), 16'h0001);
    pk = 1'b1;
    wc(9);
    pk = 1'b0;
    of = 1'b1;
    wc(40);
    chk(16'(output_on), 16'h0000);
    of = 1'b0;
    clear();
    pk = 1'b1;
    wc(9);
    pk = 1'b0;
    en = 1'b0;
    wc(40);
    en = 1'b1;
    wc(40);
    chk(16'(output_on), 16'h0000);
    clear();
  endtask

  task automatic t_store();
    wr(CMD_OC_RESP, 16'h0038);
    wr(CMD_OC_WARN, 16'he0a0);
    wr(CMD_OT_FAULT, 16'h0096);
    @(negedge clk) sto = 1'b1;
    @(negedge clk) sto = 1'b0;
    chk(16'(nv_store_valid), 16'h0001);
    chk(16'(nv_image.oc_resp), 16'h0038);
    chk(nv_image.oc_warn, 16'he0a0);
    chk(nv_image.ot_fault, 16'h0096);
    @(negedge clk);
    chk(16'(nv_store_valid), 16'h0000);
  endtask

  // Main sequence
  initial
  begin
    n_mismatch = 0;
    tests_run  = 0;
    cyc        = 0;
    {rst, link_rst} = 2'b11;
    {pk, ng, uv, en, of, clr, sto} = 7'h00;
    wc(8);
    {rst, link_rst} = 2'b00;
    t_reset();
    en = 1'b1;
    wc(10);
    t_resp();
    t_limits();
    t_peak();
    t_neg();
    act_run(8'h00, 1'b1, 1'b1, 1'b1);
    act_run(8'h40, 1'b1, 1'b1, 1'b0);
    act_run(8'h40, 1'b0, 1'b1, 1'b1);
    act_run(8'h83, 1'b0, 1'b1, 1'b0);
    act_run(8'hc0, 1'b0, 1'b0, 1'b0);
    t_hiccup();
    t_store();
    wrap_up();
  end
endmodule
